// file: spls_pkg.sv
package spls_pkg;

    // ****************************************
    // Widths and FIFO depth
    // ****************************************
    localparam int DW         = 8;
    localparam int SW         = 16;
    localparam int CW         = 4;
    localparam int PW         = 2;
    localparam int BW         = 8;
    localparam int RPW        = 8;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [CW-1:0] CONN_ID_RST  = 4'h0;
    localparam logic [PW-1:0] PORT_SEL_RST = 2'h0;

    // ****************************************
    // Requests, responses, reasons, states
    // ****************************************
    typedef enum logic [2:0] {
        OP_CONNECT = 3'h0,
        OP_LISTEN  = 3'h1,
        OP_SEND    = 3'h2,
        OP_RECEIVE = 3'h3,
        OP_CLOSE   = 3'h4,
        OP_RESET   = 3'h5
    } spls_op_e;

    typedef enum logic [1:0] {
        RSP_GOOD         = 2'h0,
        RSP_INVALID_CONN = 2'h1,
        RSP_PORT_IN_USE  = 2'h2,
        RSP_RCV_PENDING  = 2'h3
    } spls_rsp_e;

    typedef enum logic {
        closed_by_request_reason = 1'b0,
        sense_deasserted_reason  = 1'b1
    } spls_rsn_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_OPEN    = 2'b01,
        ST_CLOSING = 2'b11
    } spls_st_e;

endpackage

// file: spls_fifo_if.sv
`timescale 1ns/1ns
interface spls_fifo_if #(parameter int W = 8) ();
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    logic         afull;
    logic         flush;

    modport fill  (output in_valid, in_data, flush, out_ready,
                   input  in_ready, afull, out_valid, out_data);
    modport store (input  in_valid, in_data, flush, out_ready,
                   output in_ready, afull, out_valid, out_data);
endinterface

// file: spls_fifo.sv
`timescale 1ns/1ns
module spls_fifo
    import spls_pkg::*;
#(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    spls_fifo_if.store f
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_r;
    logic [AW:0]  rd_r;
    logic [AW:0]  lvl;
    wire          push = f.in_valid && f.in_ready;
    wire          pop  = f.out_valid && f.out_ready;

    assign lvl         = wr_r - rd_r;
    assign f.in_ready  = (lvl != D[AW:0]);
    assign f.out_valid = (lvl != '0);
    assign f.afull     = (lvl >= D[AW:0] - 1'b1);
    assign f.out_data  = mem[rd_r[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= f.in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || f.flush) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_r + {{AW{1'b0}}, push};
            rd_r <= rd_r + {{AW{1'b0}}, pop};
        end
    end
endmodule // spls_fifo

// file: spls_evt_det.sv
`timescale 1ns/1ns
module spls_evt_det
    import spls_pkg::*;
#(
    parameter int N = 1
) (
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [N-1:0] lvl,
    output logic      [N-1:0] rise,
    output logic      [N-1:0] fall
);
    logic [N-1:0] prev_r;

    assign rise = lvl & ~prev_r;
    assign fall = ~lvl & prev_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_r <= '0;
        end else begin
            prev_r <= lvl;
        end
    end
endmodule // spls_evt_det

// file: spls_port.sv
// How it works
// - Connect or listen opens the connection at once, no peer exchange.
// - Connect or listen sends nothing on the line.
// - Every accepted connect or listen raises the connected indication.
// - Connected indication may come no later than the request answer.
// - Only one connection exists; a single state holds it.
// - Further connect or listen while connected answers local port in use.
// - Local port selects the interconnect port; remote port is ignored.
// - Port assigns the connection id and checks it on later requests.
// - Send size counts encoded characters; exactly that many are sent unless a reset or sense fall aborts the send.
// - A receive never hands up more characters than its maximum.
// - Received indication returns the receive buffer and actual count.
// - After close, all accepted send characters still go out.
// - After close, characters arriving on the line are dropped.
// - While closing with data left, receives are still served.
// - Closed indication only after all received data went upward.
// - Closed reason is closed_by_request_reason or sense deasserted.
// - Reset local port selects which port sends the reset.
// - Reset received handled as port logout or hard reset.
// - Reset received indication names the port that got the reset.
// - Sense line falling may close the connection.
// - Second receive before received indication answers receive pending.
`timescale 1ns/1ns
module spls_port
    import spls_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire logic           req_valid,
    input  wire logic [2:0]     req_op,
    input  wire logic [PW-1:0]  req_local_port,
    input  wire logic [RPW-1:0] req_remote_port,
    input  wire logic [CW-1:0]  req_conn,
    input  wire logic [BW-1:0]  req_buf,
    input  wire logic [SW-1:0]  req_size,
    output logic                req_ready,
    output logic                rsp_valid,
    output logic [1:0]          rsp_code,
    output logic [CW-1:0]       rsp_conn,
    input  wire logic           tx_valid,
    input  wire logic [DW-1:0]  tx_data,
    output logic                tx_ready,
    output logic                up_rx_valid,
    output logic [DW-1:0]       up_rx_data,
    output logic                ind_connected,
    output logic                ind_received,
    output logic [BW-1:0]       ind_rcv_buf,
    output logic [SW-1:0]       ind_rcv_count,
    output logic                ind_closed,
    output logic                ind_close_reason,
    output logic [CW-1:0]       ind_conn,
    output logic                ind_reset_rcvd,
    output logic [PW-1:0]       ind_reset_port,
    input  wire logic           cfg_hard_reset,
    output logic                hard_reset_pulse,
    output logic [PW-1:0]       port_sel,
    output logic                line_tx_valid,
    output logic [DW-1:0]       line_tx_data,
    input  wire logic           line_tx_ready,
    input  wire logic           line_rx_valid,
    input  wire logic [DW-1:0]  line_rx_data,
    output logic                line_rx_ready,
    input  wire logic           sense_in,
    input  wire logic [1:0]     reset_line_in,
    output logic                reset_line_out,
    output logic [PW-1:0]       reset_out_port
);
    // ****************************************
    // State
    // ****************************************
    spls_st_e       st_r, st_nxt;
    logic [CW-1:0]  conn_r;
    logic [PW-1:0]  port_r;
    logic           reason_r;
    logic           snd_busy_r;
    logic [SW-1:0]  snd_left_r;
    logic           rcv_busy_r;
    logic [SW-1:0]  rcv_max_r;
    logic [SW-1:0]  rcv_cnt_r;
    logic [BW-1:0]  rcv_buf_r;
    logic           req_ready_r, rsp_valid_r, tx_ready_r;
    logic [1:0]     rsp_code_r;
    logic           up_rx_valid_r, ind_connected_r, ind_received_r, ind_closed_r;
    logic [DW-1:0]  up_rx_data_r, line_tx_data_r;
    logic           ind_reset_rcvd_r, hard_reset_r, line_tx_valid_r;
    logic           line_rx_ready_r, reset_line_out_r;
    logic [PW-1:0]  ind_reset_port_r, reset_out_port_r;
    logic [1:0]     rst_rise;
    logic           sense_fall;
    logic           unused_sense_rise;
    logic [1:0]     unused_rst_fall;

    spls_fifo_if #(.W(DW)) tx_if ();
    spls_fifo_if #(.W(DW)) rx_if ();

    spls_fifo #(.W(DW), .D(FIFO_DEPTH)) u_tx_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .f        (tx_if)
    );
    spls_fifo #(.W(DW), .D(FIFO_DEPTH)) u_rx_fifo (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .f        (rx_if)
    );
    spls_evt_det #(.N(3)) u_evt (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .lvl      ({sense_in, reset_line_in}),
        .rise     ({unused_sense_rise, rst_rise}),
        .fall     ({sense_fall, unused_rst_fall})
    );

    // ****************************************
    // Request decode
    // ****************************************
    wire take       = req_valid && req_ready_r;
    wire is_conn_op = (req_op == OP_CONNECT) || (req_op == OP_LISTEN);
    wire id_ok      = (st_r != ST_IDLE) && (req_conn == conn_r);
    wire conn_ok    = take && is_conn_op && (st_r == ST_IDLE);
    wire send_ok    = take && (req_op == OP_SEND) && id_ok && (st_r == ST_OPEN);
    wire rcv_ok     = take && (req_op == OP_RECEIVE) && id_ok && !rcv_busy_r;
    wire close_ok   = take && (req_op == OP_CLOSE) && id_ok && (st_r == ST_OPEN);
    wire rst_req    = take && (req_op == OP_RESET);
    wire rst_hit    = |rst_rise;
    wire drop       = rst_hit;
    wire sense_cls  = sense_fall && (st_r == ST_OPEN) && !drop;
    wire [PW-1:0] rst_port = rst_rise[0] ? 2'h0 : 2'h1;

    logic [1:0] imm_code;
    always_comb begin
        imm_code = RSP_GOOD;
        case (req_op)
            OP_CONNECT, OP_LISTEN: imm_code = conn_ok ? RSP_GOOD : RSP_PORT_IN_USE;
            OP_SEND:    imm_code = send_ok ? RSP_GOOD : RSP_INVALID_CONN;
            OP_RECEIVE: imm_code = !id_ok ? RSP_INVALID_CONN
                                 : (rcv_busy_r ? RSP_RCV_PENDING : RSP_GOOD);
            OP_CLOSE:   imm_code = close_ok ? RSP_GOOD : RSP_INVALID_CONN;
            default:    imm_code = RSP_GOOD;
        endcase
    end

    // ****************************************
    // Send path
    // ****************************************
    wire tx_push   = tx_valid && tx_ready_r;
    wire send_done = snd_busy_r && tx_push && (snd_left_r == 16'h0001);
    wire send_abrt = snd_busy_r && !send_done && (drop || sense_cls);
    wire send_long = send_ok && (req_size != 16'h0000);
    wire snd_busy_nxt = send_long || (snd_busy_r && !send_done && !send_abrt);
    wire tx_pop    = tx_if.out_valid && (!line_tx_valid_r || line_tx_ready);

    assign tx_if.in_valid  = tx_push;
    assign tx_if.in_data   = tx_data;
    assign tx_if.flush     = drop && cfg_hard_reset;
    assign tx_if.out_ready = tx_pop;

    // ****************************************
    // Receive path
    // ****************************************
    wire rx_pop    = rcv_busy_r && rx_if.out_valid && (rcv_cnt_r < rcv_max_r);
    wire rcv_fin   = rcv_busy_r && ((rcv_cnt_r == rcv_max_r)
                     || (!rx_if.out_valid && (rcv_cnt_r != 16'h0000)));
    wire closed_now = (st_r == ST_CLOSING) && !rx_if.out_valid
                      && !(rcv_busy_r && (rcv_cnt_r != 16'h0000)) && !drop;

    assign rx_if.in_valid  = line_rx_valid && (st_r == ST_OPEN);
    assign rx_if.in_data   = line_rx_data;
    assign rx_if.flush     = drop;
    assign rx_if.out_ready = rx_pop;

    // ****************************************
    // Connection state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:    st_nxt = conn_ok ? ST_OPEN : ST_IDLE;
            ST_OPEN:    st_nxt = (close_ok || sense_cls) ? ST_CLOSING : ST_OPEN;
            ST_CLOSING: st_nxt = closed_now ? ST_IDLE : ST_CLOSING;
            default:    st_nxt = ST_IDLE;
        endcase
        if (drop) begin
            st_nxt = ST_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r     <= ST_IDLE;
            conn_r   <= CONN_ID_RST;
            port_r   <= PORT_SEL_RST;
            reason_r <= closed_by_request_reason;
        end else begin
            st_r <= st_nxt;
            if (conn_ok) begin
                conn_r <= conn_r + 4'h1;
                port_r <= req_local_port;
            end
            if (close_ok || sense_cls) begin
                reason_r <= sense_cls ? sense_deasserted_reason : closed_by_request_reason;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            snd_busy_r <= 1'b0;
            snd_left_r <= '0;
            tx_ready_r <= 1'b0;
        end else begin
            snd_busy_r <= snd_busy_nxt;
            snd_left_r <= send_ok ? req_size : (snd_left_r - {15'h0000, tx_push});
            tx_ready_r <= snd_busy_nxt && !tx_if.afull && !tx_if.flush;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rcv_busy_r <= 1'b0;
            rcv_cnt_r  <= '0;
            rcv_max_r  <= '0;
            rcv_buf_r  <= '0;
        end else begin
            rcv_busy_r <= rcv_ok || (rcv_busy_r && !rcv_fin && !closed_now && !drop);
            rcv_cnt_r  <= rcv_ok ? 16'h0000 : (rcv_cnt_r + {15'h0000, rx_pop});
            if (rcv_ok) begin
                rcv_max_r <= req_size;
                rcv_buf_r <= req_buf;
            end
        end
    end

    // ****************************************
    // Registered outputs
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            req_ready_r      <= 1'b0;
            rsp_valid_r      <= 1'b0;
            rsp_code_r       <= RSP_GOOD;
            ind_connected_r  <= 1'b0;
            ind_received_r   <= 1'b0;
            ind_closed_r     <= 1'b0;
            up_rx_valid_r    <= 1'b0;
            up_rx_data_r     <= '0;
            line_rx_ready_r  <= 1'b0;
            ind_reset_rcvd_r <= 1'b0;
            ind_reset_port_r <= '0;
            hard_reset_r     <= 1'b0;
            reset_line_out_r <= 1'b0;
            reset_out_port_r <= '0;
        end else begin
            req_ready_r      <= !snd_busy_nxt;
            rsp_valid_r      <= (take && !send_long) || send_done || send_abrt;
            rsp_code_r       <= send_abrt ? RSP_INVALID_CONN : (send_done ? RSP_GOOD : imm_code);
            ind_connected_r  <= conn_ok;
            ind_received_r   <= rcv_fin && !drop;
            ind_closed_r     <= closed_now;
            up_rx_valid_r    <= rx_pop;
            up_rx_data_r     <= rx_pop ? rx_if.out_data : up_rx_data_r;
            line_rx_ready_r  <= !rx_if.afull;
            ind_reset_rcvd_r <= rst_hit;
            ind_reset_port_r <= rst_hit ? rst_port : ind_reset_port_r;
            hard_reset_r     <= rst_hit && cfg_hard_reset;
            reset_line_out_r <= rst_req;
            reset_out_port_r <= rst_req ? req_local_port : reset_out_port_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            line_tx_valid_r <= 1'b0;
            line_tx_data_r  <= '0;
        end else if (tx_pop) begin
            line_tx_valid_r <= 1'b1;
            line_tx_data_r  <= tx_if.out_data;
        end else if (line_tx_ready) begin
            line_tx_valid_r <= 1'b0;
        end
    end

    assign req_ready        = req_ready_r;
    assign rsp_valid        = rsp_valid_r;
    assign rsp_code         = rsp_code_r;
    assign rsp_conn         = conn_r;
    assign tx_ready         = tx_ready_r;
    assign up_rx_valid      = up_rx_valid_r;
    assign up_rx_data       = up_rx_data_r;
    assign ind_connected    = ind_connected_r;
    assign ind_received     = ind_received_r;
    assign ind_rcv_buf      = rcv_buf_r;
    assign ind_rcv_count    = rcv_cnt_r;
    assign ind_closed       = ind_closed_r;
    assign ind_close_reason = reason_r;
    assign ind_conn         = conn_r;
    assign ind_reset_rcvd   = ind_reset_rcvd_r;
    assign ind_reset_port   = ind_reset_port_r;
    assign hard_reset_pulse = hard_reset_r;
    assign port_sel         = port_r;
    assign line_tx_valid    = line_tx_valid_r;
    assign line_tx_data     = line_tx_data_r;
    assign line_rx_ready    = line_rx_ready_r;
    assign reset_line_out   = reset_line_out_r;
    assign reset_out_port   = reset_out_port_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_CONNECTED: assert property (conn_ok |=> ind_connected_r && rsp_valid_r
        && rsp_code_r == RSP_GOOD && st_r == ST_OPEN) else $error("connect not indicated");
    AST_NO_LINE: assert property (conn_ok && !tx_if.out_valid && !line_tx_valid_r
        |=> !line_tx_valid_r) else $error("connect sent data");
    AST_IN_USE: assert property (take && is_conn_op && st_r != ST_IDLE
        |=> rsp_valid_r && rsp_code_r == RSP_PORT_IN_USE) else $error("second connect taken");
    AST_PORT_SEL: assert property (conn_ok |=> port_sel == $past(req_local_port))
        else $error("local port not selected");
    AST_CONN_ID: assert property (conn_ok |=> conn_r == $past(conn_r) + 4'h1)
        else $error("connection id not assigned");
    AST_SEND_DONE: assert property (send_done |=> rsp_valid_r && rsp_code_r == RSP_GOOD
        && !tx_ready_r) else $error("send end wrong");
    AST_RCV_MAX: assert property (ind_received_r |-> ind_rcv_count <= rcv_max_r)
        else $error("receive over max");
    AST_RCV_PEND: assert property (take && req_op == OP_RECEIVE && id_ok && rcv_busy_r
        |=> rsp_code_r == RSP_RCV_PENDING) else $error("receive pending missed");
    AST_RX_DROP: assert property (st_r == ST_CLOSING |-> !rx_if.in_valid)
        else $error("rx taken after close");
    AST_TX_DRAIN: assert property (st_r == ST_CLOSING && tx_if.out_valid && !line_tx_valid_r
        |=> line_tx_valid_r) else $error("tx not drained");
    AST_CLOSED: assert property (ind_closed_r |-> $past(!rx_if.out_valid)
        && st_r == ST_IDLE) else $error("closed too early");
    AST_SENSE: assert property (sense_cls |=> st_r == ST_CLOSING
        && ind_close_reason == sense_deasserted_reason) else $error("sense close wrong");
    AST_RESET_OUT: assert property (rst_req |=> reset_line_out_r
        && reset_out_port_r == $past(req_local_port)) else $error("reset not sent");
    AST_RESET_IND: assert property (rst_hit |=> ind_reset_rcvd_r && st_r == ST_IDLE
        && ind_reset_port_r == $past(rst_port)) else $error("reset ind wrong");

    COV_CONNECT: cover property (conn_ok ##[1:50] send_done);
    COV_RECEIVE: cover property (rcv_ok ##[1:50] ind_received_r);
    COV_CLOSE: cover property (close_ok ##[1:100] ind_closed_r);
endmodule // spls_port

// file: spls_peer.sv
`timescale 1ns/1ns
module spls_peer
    import spls_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          sys_rst,
    input  wire logic          slow,
    input  wire logic          line_tx_valid,
    input  wire logic [DW-1:0] line_tx_data,
    output logic               line_tx_ready,
    output logic               line_rx_valid,
    output logic [DW-1:0]      line_rx_data
);
    logic [DW-1:0] got_q[$];
    logic [DW-1:0] snd_q[$];
    logic          tick_r = 1'b0;

    initial begin
        line_tx_ready = 1'b0;
        line_rx_valid = 1'b0;
        line_rx_data  = 8'h00;
    end

    always @(posedge core_clk) begin
        tick_r <= ~tick_r;
        if (line_tx_valid === 1'b1 && line_tx_ready) got_q.push_back(line_tx_data);
        line_tx_ready <= !sys_rst && (!slow || tick_r);
        if (!sys_rst && snd_q.size() > 0) begin
            line_rx_valid <= 1'b1;
            line_rx_data  <= snd_q.pop_front();
        end else begin
            line_rx_valid <= 1'b0;
            line_rx_data  <= ~line_rx_data;
        end
    end
endmodule // spls_peer

// file: serial_port_link_services_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module serial_port_link_services_test import spls_pkg::*;;
    logic core_clk = 0, sys_rst = 1, req_valid = 0, tx_valid = 0, cfg_hard_reset = 0;
    logic sense_in = 1, slow = 0;
    logic [2:0] req_op = 0;
    logic [PW-1:0] req_local_port = 0, ind_reset_port, port_sel, reset_out_port;
    logic [RPW-1:0] req_remote_port = 8'hC3;
    logic [CW-1:0] req_conn = 0, cid, rsp_conn, ind_conn;
    logic [BW-1:0] req_buf = 0, ind_rcv_buf;
    logic [SW-1:0] req_size = 0, ind_rcv_count;
    logic [DW-1:0] tx_data = 0, line_rx_data, line_tx_data, up_rx_data, nxt = 8'h40;
    logic [1:0] reset_line_in = 0, rsp_code;
    logic req_ready, rsp_valid, tx_ready, up_rx_valid, ind_connected, ind_received, ind_closed;
    logic ind_close_reason, ind_reset_rcvd, hard_reset_pulse, line_tx_valid, line_tx_ready;
    logic line_rx_valid, line_rx_ready, reset_line_out;
    logic [DW-1:0] exp_q[$], up_q[$];
    int num_errors = 0, checked = 0, n_conn = 0, n_closed = 0, n_rcvd = 0, n_rrst = 0;
    int n_hard = 0, n_up = 0, n_ltx = 0;

    spls_port spls_port_i (.*);
    spls_peer spls_peer_i (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
        .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data),
        .line_tx_ready(line_tx_ready), .line_rx_valid(line_rx_valid),
        .line_rx_data(line_rx_data));

    always #4 core_clk = ~core_clk;

    // ****************************************
    // Event counters
    // ****************************************
    always @(posedge core_clk) begin
        if (ind_connected === 1'b1) n_conn <= n_conn + 1;
        if (ind_closed === 1'b1) n_closed <= n_closed + 1;
        if (ind_received === 1'b1) n_rcvd <= n_rcvd + 1;
        if (ind_reset_rcvd === 1'b1) n_rrst <= n_rrst + 1;
        if (hard_reset_pulse === 1'b1) n_hard <= n_hard + 1;
        if (up_rx_valid === 1'b1) begin
            n_up <= n_up + 1;
            up_q.push_back(up_rx_data);
        end
        if (line_tx_valid === 1'b1) n_ltx <= n_ltx + 1;
    end

    task automatic upto(ref int cnt, input int v);
        int n;
        n = 0;
        while (cnt < v && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (cnt < v) num_errors++;
    endtask

    task automatic go(input logic [2:0] op, input logic [PW-1:0] lp, input logic [CW-1:0] cn,
                      input logic [BW-1:0] bf, input logic [SW-1:0] sz, output logic [1:0] c);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_op <= op;
        req_local_port <= lp;
        req_conn <= cn;
        req_buf <= bf;
        req_size <= sz;
        @(posedge core_clk);
        while (req_ready !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        req_valid <= 1'b0;
        @(posedge core_clk);
        while (rsp_valid !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 300) num_errors++;
        c = rsp_code;
    endtask

    task automatic send(input logic [CW-1:0] cn, input int sz, output logic [1:0] c);
        fork
            go(OP_SEND, 0, cn, 0, SW'(sz), c);
            for (int i = 0; i < sz; i++) begin
                tx_valid <= 1'b1;
                tx_data <= nxt;
                exp_q.push_back(nxt);
                nxt = nxt + 8'h01;
                @(posedge core_clk);
                while (tx_ready !== 1'b1) @(posedge core_clk);
                if (i == sz - 1) tx_valid <= 1'b0;
            end
        join
    endtask

    task automatic feed(input int k, input logic [DW-1:0] b);
        for (int i = 0; i < k; i++) spls_peer_i.snd_q.push_back(b + DW'(i));
        repeat (k + 6) @(posedge core_clk);
    endtask

    task automatic rcv(input logic [SW-1:0] mx, input int ex, input logic [DW-1:0] b);
        logic [1:0] c;
        int r0, u0;
        r0 = n_rcvd;
        u0 = n_up;
        go(OP_RECEIVE, 0, cid, 8'hA5, mx, c);
        `CHK("rcv rsp", RSP_GOOD, c)
        upto(n_rcvd, r0 + 1);
        `CHK("rcv count", SW'(ex), ind_rcv_count)
        `CHK("rcv buf", 8'hA5, ind_rcv_buf)
        `CHK("up chars", ex, n_up - u0)
        for (int i = 0; i < ex; i++) `CHK("up data", b + DW'(i), up_q[u0 + i])
    endtask

    task automatic t_line;
        int n;
        n = 0;
        while (spls_peer_i.got_q.size() < exp_q.size() && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        `CHK("line count", exp_q.size(), spls_peer_i.got_q.size())
        foreach (exp_q[i]) `CHK("line char", exp_q[i], spls_peer_i.got_q[i])
    endtask

    task automatic t_open;
        logic [1:0] c;
        int c0, l0;
        c0 = n_conn;
        l0 = n_ltx;
        `CHK("rx room", 1'b1, line_rx_ready)
        go(OP_CONNECT, 2'h2, 0, 0, 0, c);
        `CHK("connect", RSP_GOOD, c)
        `CHK("ind with rsp", 1'b1, ind_connected)
        cid = rsp_conn;
        @(posedge core_clk);
        `CHK("connected ind", c0 + 1, n_conn)
        `CHK("port sel", 2'h2, port_sel)
        go(OP_LISTEN, 2'h1, 0, 0, 0, c);
        `CHK("listen again", RSP_PORT_IN_USE, c)
        go(OP_CONNECT, 2'h1, 0, 0, 0, c);
        `CHK("connect again", RSP_PORT_IN_USE, c)
        `CHK("port kept", 2'h2, port_sel)
        `CHK("conn id", cid, ind_conn)
        `CHK("line quiet", l0, n_ltx)
    endtask

    task automatic t_traffic;
        logic [1:0] c;
        int r0;
        go(OP_SEND, 0, cid + 4'h1, 0, 16'h0002, c);
        `CHK("bad id", RSP_INVALID_CONN, c)
        slow <= 1'b1;
        send(cid, 3, c);
        `CHK("send", RSP_GOOD, c)
        t_line;
        rcv(16'h0000, 0, 8'h00);
        feed(5, 8'h10);
        rcv(16'h0003, 3, 8'h10);
        rcv(16'h0004, 2, 8'h13);
        go(OP_RECEIVE, 0, cid, 8'h5A, 16'h0004, c);
        go(OP_RECEIVE, 0, cid, 8'h5A, 16'h0004, c);
        `CHK("rcv twice", RSP_RCV_PENDING, c)
        r0 = n_rcvd;
        feed(1, 8'h50);
        upto(n_rcvd, r0 + 1);
        `CHK("late count", 16'h0001, ind_rcv_count)
    endtask

    task automatic t_close;
        logic [1:0] c;
        int k;
        k = n_closed;
        feed(3, 8'h20);
        send(cid, 4, c);
        go(OP_CLOSE, 0, cid, 0, 0, c);
        `CHK("close", RSP_GOOD, c)
        feed(2, 8'h60);
        repeat (20) @(posedge core_clk);
        `CHK("closed early", k, n_closed)
        rcv(16'h0008, 3, 8'h20);
        upto(n_closed, k + 1);
        `CHK("closed", k + 1, n_closed)
        `CHK("reason req", closed_by_request_reason, ind_close_reason)
        `CHK("closed id", cid, ind_conn)
        t_line;
        slow <= 1'b0;
        t_open;
    endtask

    task automatic t_reset;
        logic [1:0] c;
        int k, h;
        k = n_closed;
        sense_in <= 1'b0;
        upto(n_closed, k + 1);
        `CHK("sense close", sense_deasserted_reason, ind_close_reason)
        sense_in <= 1'b1;
        t_open;
        go(OP_RESET, 2'h3, 0, 0, 0, c);
        `CHK("reset out", 1'b1, reset_line_out)
        `CHK("reset port", 2'h3, reset_out_port)
        for (int p = 1; p >= 0; p--) begin
            k = n_closed;
            h = n_hard;
            cfg_hard_reset <= p[0];
            reset_line_in <= 2'(1 << p);
            upto(n_rrst, n_rrst + 1);
            repeat (3) @(posedge core_clk);
            `CHK("reset rcvd port", PW'(p), ind_reset_port)
            `CHK("hard pulses", h + p, n_hard)
            `CHK("no closed", k, n_closed)
            reset_line_in <= 2'b00;
            t_open;
        end
    endtask

    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        t_open;
        t_traffic;
        t_close;
        t_reset;
        tally_and_finish;
    end
endmodule // serial_port_link_services_test
